/* include/pilc_pkg.sv */
package pilc_pkg;
	localparam int NUM_LVL = 32;
	localparam int NUM_EXT = 6;
	localparam int NUM_PER = 9;
	// printed offsets are register indices; byte address is four times this
	localparam logic [7:0] IDX_EN0 = 8'h3a;
	localparam logic [7:0] IDX_EN1 = 8'h3b;
	localparam logic [7:0] IDX_EN2 = 8'h2c;
	localparam logic [7:0] IDX_EN3 = 8'h2d;
	localparam logic [7:0] IDX_PEND0 = 8'h3c;
	localparam logic [7:0] IDX_PEND1 = 8'h3d;
	localparam logic [7:0] IDX_PEND2 = 8'h2e;
	localparam logic [7:0] IDX_PEND3 = 8'h2f;
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_STAT = 8'h31;
	localparam int IMF_BIT = 0;
	localparam int LVL_SWTRAP = 1;
	localparam int LVL_WDT = 2;
	localparam int LVL_EXT0 = 3;
	// external pins in order: ext0, key wakeup, ext2, ext3, ext4, ext5
	localparam int EXT_POS [NUM_EXT] = '{3, 5, 7, 11, 12, 15};
	// peripherals: watchdog, timer1, time base, timer3, serial bus,
	// timer4, converter, timer2, screen overlay
	localparam int PER_POS [NUM_PER] = '{2, 4, 6, 8, 9, 10, 13, 14, 16};
	localparam logic [31:0] LATCH_RST = 32'h0000_0000;
	localparam logic [31:0] EN_RST = 32'h0000_0000;
	localparam logic [31:0] SW_CLR_MASK = 32'hffff_fff8;
	localparam logic [31:0] EN_MASK = 32'hffff_fff9;
	localparam logic [31:0] MASKABLE = 32'hffff_fff8;
	localparam logic [19:0] VEC_TOP = 20'hf_fffc;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MACH_CYCLE_NS = 250;
	localparam int ACCEPT_MACH = 12;
	localparam int MACH_CLKS =
		(MACH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACCEPT_CLKS = ACCEPT_MACH * MACH_CLKS;
	localparam int CNT_W = 11;
	typedef enum logic [1:0] {
		PILC_IDLE = 2'b01,
		PILC_ACCEPT = 2'b10
	} pilc_state_t;
	typedef struct packed {
		logic [4:0] level;
		logic [19:0] vector;
	} pilc_grant_t;
endpackage

/* verilog/pilc_pin_sync.sv */
module pilc_pin_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] rise_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, filt_reg, rise_reg;
	logic [WIDTH-1:0] filt_next, rise_next;

	// a level only counts once the second and third stage agree
	always_comb begin
		filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
		rise_next = filt_next & ~filt_reg;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
			rise_reg <= '0;
		end else if (ce_in) begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			rise_reg <= rise_next;
		end
	end

	assign rise_out = rise_reg;
endmodule // pilc_pin_sync

/* verilog/pilc_top.sv */
// Behaviour
// - sixteen sources: six external pins, nine internal peripheral requests and the software trap.
// - each source has its own vector, all but the software trap a request latch; set latch asks CPU.
// - several pending: fixed priority, level 0 highest, 31 lowest.
// - non-maskable class is not ranked against itself; here the trap, level 1, wins over the watchdog, level 2.
// - vector is FFFFCH minus four per level, down to FFF80H.
// - maskable needs master enable and own enable; ext0 also its pin gate.
// - software trap and watchdog ignore master and per-source enables.
// - every source but software trap has a latch; positions 2 to 16.
// - accepted source's latch clears right after acceptance.
// - reset forces all request latches to zero.
// - latches sit at register indices 3C, 3D, 2E and 2F.
// - software write clears any single latch, except the watchdog latch.
// - software writes never set a latch; only hardware requests do.
// - reading latch registers returns the current pending state.
// - accepting an interrupt clears master enable to zero.
// - acceptance takes 12 machine cycles after the instruction ends.
// - master enable is bit 0 at index 3A, read/write, zero at reset.
//
// Design decision made here: the Avalon-MM interface to the registers.
module pilc_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [9:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [pilc_pkg::NUM_EXT-1:0] ext_pin_in,
	input wire logic [pilc_pkg::NUM_PER-1:0] periph_req_in,
	input wire logic software_trap_in,
	input wire logic instr_done_in,
	input wire logic reti_in,
	input wire logic retn_in,
	output logic irq_pending_out,
	output logic accept_busy_out,
	output pilc_pkg::pilc_grant_t grant_out,
	output logic grant_valid_out
);
	import pilc_pkg::*;

	logic [31:0] latch_reg, latch_next, en_reg, en_next;
	logic ext0_gate_reg, ext0_gate_next;
	logic nmi_busy_reg, nmi_busy_next, imf_saved_reg, imf_saved_next;
	pilc_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	pilc_grant_t grant_reg, grant_next;
	logic gvalid_reg, gvalid_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [NUM_EXT-1:0] ext_rise;
	logic [31:0] set_vec, elig, clr_vec, wr_byte;
	logic [4:0] win;
	logic [7:0] idx;
	logic bus_req, wr_fire, take;

	pilc_pin_sync #(.WIDTH(NUM_EXT)) u_pin_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.pin_in(ext_pin_in),
		.rise_out(ext_rise)
	);

	// request sources mapped onto latch positions; reserved ones stay 0
	always_comb begin
		set_vec = '0;
		for (int i = 0; i < NUM_EXT; i++) begin
			set_vec[EXT_POS[i]] = ext_rise[i];
		end
		for (int i = 0; i < NUM_PER; i++) begin
			set_vec[PER_POS[i]] = periph_req_in[i];
		end
	end

	// eligibility per level
	always_comb begin
		elig = latch_reg & en_reg & MASKABLE & {32{en_reg[IMF_BIT]}};
		elig[LVL_EXT0] = elig[LVL_EXT0] & ext0_gate_reg;
		// the trap has no latch; the CPU holds its line until accepted
		elig[LVL_SWTRAP] = software_trap_in & ~nmi_busy_reg;
		elig[LVL_WDT] = latch_reg[LVL_WDT] & ~nmi_busy_reg;
	end

	// lowest index wins; the two pseudo non-maskable levels can be eligible
	// together, then the trap at level 1 wins; the busy flag admits one at a time
	always_comb begin
		win = 5'h00;
		for (int i = NUM_LVL - 1; i >= 0; i--) begin
			if (elig[i]) begin
				win = 5'(i);
			end
		end
	end

	assign take = ce_in && state_reg == PILC_IDLE && instr_done_in && |elig;
	assign irq_pending_out = state_reg == PILC_IDLE && |elig;
	assign accept_busy_out = state_reg == PILC_ACCEPT;

	// bus: one wait state, read data captured in the waiting cycle
	assign bus_req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~ack_reg;
	assign idx = avs_address_in[9:2];
	assign wr_fire = avs_write_in & ack_reg & avs_byteenable_in[0];
	assign avs_readdata_out = rdata_reg;

	always_comb begin
		rdata_next = rdata_reg;
		ack_next = bus_req & ~ack_reg;
		if (bus_req && !ack_reg) begin
			case (idx)
				IDX_PEND0: rdata_next = {24'h00_0000, latch_reg[7:0]};
				IDX_PEND1: rdata_next = {24'h00_0000, latch_reg[15:8]};
				IDX_PEND2: rdata_next = {24'h00_0000, latch_reg[23:16]};
				IDX_PEND3: rdata_next = {24'h00_0000, latch_reg[31:24]};
				IDX_EN0: rdata_next = {24'h00_0000, en_reg[7:0]};
				IDX_EN1: rdata_next = {24'h00_0000, en_reg[15:8]};
				IDX_EN2: rdata_next = {24'h00_0000, en_reg[23:16]};
				IDX_EN3: rdata_next = {24'h00_0000, en_reg[31:24]};
				IDX_CTRL: rdata_next = {31'h0000_0000, ext0_gate_reg};
				IDX_STAT: rdata_next = {24'h00_0000, nmi_busy_reg,
					accept_busy_out, 1'b0, grant_reg.level};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// write data placed in the byte lane its index selects
	always_comb begin
		wr_byte = '0;
		clr_vec = '0;
		case (idx)
			IDX_PEND0, IDX_EN0: wr_byte[7:0] = avs_writedata_in[7:0];
			IDX_PEND1, IDX_EN1: wr_byte[15:8] = avs_writedata_in[7:0];
			IDX_PEND2, IDX_EN2: wr_byte[23:16] = avs_writedata_in[7:0];
			IDX_PEND3, IDX_EN3: wr_byte[31:24] = avs_writedata_in[7:0];
			default: wr_byte = '0;
		endcase
		if (wr_fire) begin
			case (idx)
				IDX_PEND0: clr_vec[7:0] = ~wr_byte[7:0];
				IDX_PEND1: clr_vec[15:8] = ~wr_byte[15:8];
				IDX_PEND2: clr_vec[23:16] = ~wr_byte[23:16];
				IDX_PEND3: clr_vec[31:24] = ~wr_byte[31:24];
				default: clr_vec = '0;
			endcase
		end
		clr_vec = clr_vec & SW_CLR_MASK;
	end

	// latches: software may only clear (a zero bit clears); new requests
	// win over any clear in the same cycle, so read-modify-write by
	// software is what loses them, not this logic
	always_comb begin
		latch_next = latch_reg & ~clr_vec;
		if (take) begin
			latch_next[win] = 1'b0;
		end
		// positions 0 and 1 own no latch (reset, trap)
		latch_next = (latch_next | set_vec) & ~32'h0000_0003;
	end

	always_comb begin
		en_next = en_reg;
		ext0_gate_next = ext0_gate_reg;
		nmi_busy_next = nmi_busy_reg;
		imf_saved_next = imf_saved_reg;
		if (wr_fire) begin
			case (idx)
				IDX_EN0: en_next[7:0] = wr_byte[7:0] & EN_MASK[7:0];
				IDX_EN1: en_next[15:8] = wr_byte[15:8];
				IDX_EN2: en_next[23:16] = wr_byte[23:16];
				IDX_EN3: en_next[31:24] = wr_byte[31:24];
				IDX_CTRL: ext0_gate_next = avs_writedata_in[0];
				default: en_next = en_reg;
			endcase
		end
		if (reti_in) begin
			en_next[IMF_BIT] = 1'b1;
		end
		if (retn_in) begin
			nmi_busy_next = 1'b0;
			en_next[IMF_BIT] = en_next[IMF_BIT] | imf_saved_reg;
		end
		if (take) begin
			en_next[IMF_BIT] = 1'b0;
			if (win <= 5'(LVL_WDT)) begin
				nmi_busy_next = 1'b1;
				imf_saved_next = en_reg[IMF_BIT];
			end
		end
	end

	// acceptance sequence
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		grant_next = grant_reg;
		gvalid_next = 1'b0;
		case (state_reg)
			PILC_IDLE: begin
				if (take) begin
					state_next = PILC_ACCEPT;
					cnt_next = CNT_W'(ACCEPT_CLKS - 1);
					grant_next.level = win;
					grant_next.vector = VEC_TOP - 20'({win, 2'b00});
				end
			end
			PILC_ACCEPT: begin
				if (cnt_reg == '0) begin
					state_next = PILC_IDLE;
					gvalid_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default: state_next = PILC_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch_reg <= LATCH_RST;
			en_reg <= EN_RST;
			ext0_gate_reg <= 1'b0;
			nmi_busy_reg <= 1'b0;
			imf_saved_reg <= 1'b0;
			state_reg <= PILC_IDLE;
			cnt_reg <= '0;
			grant_reg <= '0;
			gvalid_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (ce_in) begin
			latch_reg <= latch_next;
			en_reg <= en_next;
			ext0_gate_reg <= ext0_gate_next;
			nmi_busy_reg <= nmi_busy_next;
			imf_saved_reg <= imf_saved_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			grant_reg <= grant_next;
			gvalid_reg <= gvalid_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign grant_out = grant_reg;
	assign grant_valid_out = gvalid_reg;

	// checking helpers
	logic take_q, setwin_q;
	logic [4:0] win_q;
	logic [CNT_W-1:0] len_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			take_q <= 1'b0;
			setwin_q <= 1'b0;
			win_q <= '0;
			len_q <= '0;
		end else begin
			take_q <= take;
			setwin_q <= set_vec[win];
			win_q <= win;
			if (take) begin
				len_q <= '0;
			end else if (ce_in && state_reg == PILC_ACCEPT) begin
				len_q <= len_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_latch_clear_accept: assert property (
		take_q && !setwin_q |-> !latch_reg[win_q])
		else $error("accepted latch not cleared");
	a_imf_drop_accept: assert property (
		take_q |-> !en_reg[IMF_BIT])
		else $error("master enable kept after acceptance");
	a_fixed_prio: assert property (
		take |-> (elig & ((32'h0000_0001 << win) - 32'h0000_0001)) == '0)
		else $error("lower priority level granted");
	a_mask_gate: assert property (
		take && win >= 5'(LVL_EXT0) |-> en_reg[IMF_BIT] && en_reg[win])
		else $error("masked source granted");
	a_ext0_gate: assert property (
		take && win == 5'(LVL_EXT0) |-> ext0_gate_reg)
		else $error("ext0 granted with gate closed");
	a_wdt_kept: assert property (
		latch_reg[LVL_WDT] && !(take && win == 5'(LVL_WDT))
		|=> latch_reg[LVL_WDT])
		else $error("watchdog latch lost");
	a_no_sw_set: assert property (
		(latch_reg & ~$past(latch_reg) & ~$past(set_vec)) == '0)
		else $error("latch set without request");
	a_reserved_idle: assert property (
		latch_reg[31:17] == '0)
		else $error("reserved latch pending");
	a_accept_len: assert property (
		gvalid_reg |-> len_q == CNT_W'(ACCEPT_CLKS))
		else $error("acceptance length wrong");
	a_vector_map: assert property (
		gvalid_reg |-> grant_reg.vector[1:0] == 2'b00 &&
		20'(grant_reg.vector + {grant_reg.level, 2'b00}) == VEC_TOP)
		else $error("vector address wrong");
	a_wait_once: assert property (
		bus_req && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out)
		else $error("waitrequest held too long");

	c_masked_take: cover property (take && win >= 5'(LVL_EXT0));
	c_wdt_take: cover property (take && win == 5'(LVL_WDT));
	c_sw_clear: cover property (wr_fire && idx == IDX_PEND0);
	c_both_nmi: cover property (elig[LVL_SWTRAP] && elig[LVL_WDT]);
endmodule // pilc_top

/* tb/pilc_cpu_model.sv */
module pilc_cpu_model (
	input wire logic clk_in,
	input wire logic accept_busy_in,
	input wire pilc_pkg::pilc_grant_t grant_in,
	input wire logic grant_valid_in,
	output logic instr_done_out,
	output logic reti_out,
	output logic retn_out,
	output logic software_trap_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import pilc_pkg::*;
	initial begin
		instr_done_out = 1'b0;
		reti_out = 1'b0;
		retn_out = 1'b0;
		software_trap_out = 1'b0;
	end
	task automatic trap();
		@(posedge clk_in);
		software_trap_out <= 1'b1;
	endtask
	task automatic ret(input logic nm);
		@(posedge clk_in);
		if (nm) begin
			retn_out <= 1'b1;
		end else begin
			reti_out <= 1'b1;
		end
		@(posedge clk_in);
		retn_out <= 1'b0;
		reti_out <= 1'b0;
	endtask
	// one boundary pulse, then count cycles until the grant shows
	task automatic accept(output pilc_grant_t g, output int n,
		output logic ok);
		@(posedge clk_in);
		instr_done_out <= 1'b1;
		@(posedge clk_in);
		instr_done_out <= 1'b0;
		n = 0;
		ok = 1'b1;
		do begin
			@(negedge clk_in);
			n++;
			if (grant_valid_in !== 1'b1 && accept_busy_in !== 1'b1) begin
				ok = 1'b0;
			end
		end while (grant_valid_in !== 1'b1 && n < 2000);
		g = grant_in;
		@(posedge clk_in);
		// trap line is a level, held until its own grant
		if (g.level === 5'd1) begin
			software_trap_out <= 1'b0;
		end
	endtask
endmodule // pilc_cpu_model

/* tb/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pilc_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [9:0] adr = '0;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wdat = '0;
	logic ce = 1'b1;
	logic [3:0] be = 4'h1;
	logic [31:0] rdat;
	logic waitreq;
	logic [NUM_EXT-1:0] ext = '0;
	logic [NUM_PER-1:0] periph = '0;
	logic swtrap, idone, reti, retn, pend, busy, gvalid;
	pilc_grant_t grant;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	pilc_top dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
		.avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(waitreq),
		.ext_pin_in(ext), .periph_req_in(periph),
		.software_trap_in(swtrap), .instr_done_in(idone),
		.reti_in(reti), .retn_in(retn), .irq_pending_out(pend),
		.accept_busy_out(busy), .grant_out(grant),
		.grant_valid_out(gvalid));
	pilc_cpu_model cpu (.clk_in(clk_in), .accept_busy_in(busy),
		.grant_in(grant), .grant_valid_in(gvalid),
		.instr_done_out(idone), .reti_out(reti), .retn_out(retn),
		.software_trap_out(swtrap));
	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic summarize();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// generous ceiling: six acceptances of 600 cycles plus bus traffic
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until the rising edge that sees waitrequest low;
	// only the cycle ceiling ends a wait that never finishes
	task automatic bus(input logic [7:0] idx, input logic w,
		input logic [7:0] v, output logic [31:0] d);
		@(posedge clk_in);
		adr <= {idx, 2'b00};
		wdat <= {24'h00_0000, v};
		if (w) wr_s <= 1'b1;
		else rd_s <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (waitreq !== 1'b0);
		d = rdat;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		bus(idx, 1'b1, v, d);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] d;
		bus(idx, 1'b0, 8'h00, d);
		chk($sformatf("reg_%h", idx), {24'h00_0000, e}, d);
	endtask
	task automatic pchk(input logic e);
		@(negedge clk_in);
		chk("irq_pending", 32'(e), 32'(pend));
	endtask
	task automatic pulse(input logic [NUM_PER-1:0] v);
		@(posedge clk_in);
		periph <= v;
		@(posedge clk_in);
		periph <= '0;
	endtask
	task automatic acc(input logic [4:0] lv, input logic [19:0] v);
		pilc_grant_t g;
		int n;
		logic ok;
		cpu.accept(g, n, ok);
		chk("grant_level", 32'(lv), 32'(g.level));
		chk("grant_vector", 32'(v), 32'(g.vector));
		// valid lands 600 edges after the taking edge
		chk("accept_clks", 32'(ACCEPT_CLKS + 1), 32'(n));
		chk("accept_busy", 32'(1'b1), 32'(ok));
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rdchk(IDX_PEND0, 8'h00);
		rdchk(IDX_PEND1, 8'h00);
		rdchk(IDX_PEND2, 8'h00);
		rdchk(IDX_PEND3, 8'h00);
		rdchk(IDX_EN0, 8'h00);
		// clock enable low: a request pulse must leave no trace
		ce <= 1'b0;
		pulse(9'h002);
		@(posedge clk_in);
		ce <= 1'b1;
		rdchk(IDX_PEND0, 8'h00);
		wr(8'h00, 8'hff);
		rdchk(8'h00, 8'h00);
		wr(IDX_EN0, 8'hff);
		rdchk(IDX_EN0, 8'hf9);
		wr(IDX_EN2, 8'hff);
		rdchk(IDX_EN2, 8'hff);
		wr(IDX_EN0, 8'h00);
		wr(IDX_EN2, 8'h00);
		// byte lane 0 disabled: the write must be dropped
		be <= 4'he;
		wr(IDX_EN0, 8'hff);
		be <= 4'h1;
		rdchk(IDX_EN0, 8'h00);
		pulse('1);
		rdchk(IDX_PEND0, 8'h54);
		rdchk(IDX_PEND1, 8'h67);
		rdchk(IDX_PEND2, 8'h01);
		rdchk(IDX_PEND3, 8'h00);
		@(posedge clk_in);
		ext <= '1;
		repeat (8) @(posedge clk_in);
		ext <= '0;
		rdchk(IDX_PEND0, 8'hfc);
		rdchk(IDX_PEND1, 8'hff);
		// plain loads only, master enable already low
		wr(IDX_PEND0, 8'h00);
		rdchk(IDX_PEND0, 8'h04);
		wr(IDX_PEND3, 8'hff);
		rdchk(IDX_PEND3, 8'h00);
		wr(IDX_PEND2, 8'hfe);
		rdchk(IDX_PEND2, 8'h00);
		pchk(1'b1);
		acc(5'd2, 20'hf_fff4);
		rdchk(IDX_PEND0, 8'h00);
		cpu.ret(1'b1);
		pchk(1'b0);
		wr(IDX_EN1, 8'h88);
		pchk(1'b0);
		wr(IDX_EN0, 8'h01);
		acc(5'd11, 20'hf_ffd0);
		rdchk(IDX_EN0, 8'h00);
		rdchk(IDX_PEND1, 8'hf7);
		cpu.ret(1'b0);
		acc(5'd15, 20'hf_ffc0);
		cpu.ret(1'b0);
		wr(IDX_EN0, 8'h00);
		@(posedge clk_in);
		ext <= 6'h01;
		repeat (8) @(posedge clk_in);
		wr(IDX_EN0, 8'h08);
		wr(IDX_EN0, 8'h09);
		pchk(1'b0);
		wr(IDX_CTRL, 8'h01);
		pchk(1'b1);
		acc(5'd3, 20'hf_fff0);
		cpu.ret(1'b0);
		cpu.trap();
		pulse(9'h001);
		acc(5'd1, 20'hf_fff8);
		cpu.ret(1'b1);
		rdchk(IDX_EN0, 8'h09);
		acc(5'd2, 20'hf_fff4);
		cpu.ret(1'b1);
		pulse('1);
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rdchk(IDX_PEND0, 8'h00);
		rdchk(IDX_PEND1, 8'h00);
		rdchk(IDX_PEND2, 8'h00);
		rdchk(IDX_EN0, 8'h00);
		summarize();
	end
endmodule // tb_top
